// ### hdl/wwt_core.sv
`timescale 1ns/1ps
// Functional notes
// - Normal mode time-out length comes from timeout_period_sel.
// - Writing enable starts counting; an uncleared expiry requests system reset.
// - Clear write of key 0xA5 restarts the counter and period.
// - Clear write of any other value resets the system immediately.
// - Twelve period choices from 8 ms up to 16 s.
// - Early warning enable is off at reset, set and cleared by strobes.
// - Normal mode early warning fires at point given by early_warn_offset.
// - Early warning offset counts oscillator cycles from period start.
// - Warning point beyond time-out means reset first and no warning.
// - Period code 2, offset 1: warning at 16, reset at 32 cycles.
// - Window mode accepts key only during the open window.
// - Window mode clear during closed window resets the system.
// - Closed window from window period field, open window from period field.
// - Window durations 8 ms to 16 s; total period is their sum.
// - Window mode warning fires exactly when the open window begins.
module wwt_core #(
  parameter int unsigned CW = wwt_pkg::CNT_W
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          osc_clk_in,
  input  wire logic          enable,
  input  wire logic          window_mode,
  input  wire logic [3:0]    timeout_period_sel,
  input  wire logic [3:0]    window_period_sel,
  input  wire logic [3:0]    early_warn_offset,
  input  wire logic          clear_wr,
  input  wire logic [7:0]    clear_data,
  input  wire logic          int_en_set_wr,
  input  wire logic          int_en_clr_wr,
  input  wire logic          flag_wr,
  input  wire logic          flag_wr_data,
  output logic               sys_reset_req,
  output logic               early_warn_int,
  output logic               early_warn_flag,
  output logic               early_warn_int_en,
  output logic [CW-1:0]      count,
  output wwt_pkg::wwt_phase_t phase
);

  logic [CW-1:0]  sel_cyc [3];
  logic [3:0]     sel_in  [3];
  logic [CW-1:0]  count_q;
  logic [CW-1:0]  count_inc;
  logic [CW-1:0]  to_cyc;
  logic [CW-1:0]  win_cyc;
  logic [CW-1:0]  ew_cyc;
  logic [CW-1:0]  limit;
  logic           osc_q;
  logic           tick;
  logic           expire;
  logic           key_ok;
  logic           in_closed;
  logic           clr_bad;
  logic           clr_good;
  logic           ew_hit;
  logic           rst_req_q;
  logic           int_en_q;
  logic           flag_q;

  assign sel_in[0] = timeout_period_sel;
  assign sel_in[1] = window_period_sel;
  assign sel_in[2] = early_warn_offset;

  // One shared decoder shape keeps all three durations on the same scale.
  for (genvar i = 0; i < 3; i++) begin : g_dec
    wwt_period_dec #(
      .CW     (CW)
    ) u_dec (
      .sel    (sel_in[i]),
      .cycles (sel_cyc[i])
    );
  end

  assign to_cyc  = sel_cyc[0];
  assign win_cyc = sel_cyc[1];
  assign ew_cyc  = sel_cyc[2];

  // The oscillator is slow against core_clk, so one rising edge is one count.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_clk_in;
    end
  end

  assign tick      = osc_clk_in & ~osc_q;
  assign count_inc = count_q + CW'(1);
  assign limit     = window_mode ? CW'(win_cyc + to_cyc) : to_cyc;
  assign expire    = enable & tick & (count_inc >= limit);
  assign key_ok    = clear_data == wwt_pkg::CLEAR_KEY;
  assign in_closed = window_mode & (count_q < win_cyc);
  assign clr_bad   = enable & clear_wr & (~key_ok | in_closed);
  assign clr_good  = enable & clear_wr & key_ok & ~in_closed;

  // Normal mode warns at the offset only if it lands inside the period.
  always_comb begin
    if (window_mode) begin
      ew_hit = enable & tick & (count_inc == win_cyc);
    end else begin
      ew_hit = enable & tick & (count_inc == ew_cyc) & (ew_cyc < to_cyc);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= CW'(wwt_pkg::CNT_RESET);
    end else if (!enable || expire || clr_bad || clr_good) begin
      count_q <= CW'(wwt_pkg::CNT_RESET);
    end else if (tick) begin
      count_q <= count_inc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= expire | clr_bad;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_en_q <= wwt_pkg::INT_EN_RESET;
    end else if (int_en_set_wr) begin
      int_en_q <= 1'b1;
    end else if (int_en_clr_wr) begin
      int_en_q <= 1'b0;
    end
  end

  // A warning landing with the clear write still sets the flag.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_q <= wwt_pkg::FLAG_RESET;
    end else if (ew_hit) begin
      flag_q <= 1'b1;
    end else if (flag_wr && flag_wr_data) begin
      flag_q <= 1'b0;
    end
  end

  always_comb begin
    if (!enable) begin
      phase = wwt_pkg::WWT_IDLE;
    end else if (in_closed) begin
      phase = wwt_pkg::WWT_CLOSED;
    end else begin
      phase = wwt_pkg::WWT_OPEN;
    end
  end

  assign sys_reset_req     = rst_req_q;
  assign early_warn_flag   = flag_q;
  assign early_warn_int_en = int_en_q;
  assign early_warn_int    = flag_q & int_en_q;
  assign count             = count_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_bad_key;
    enable && clear_wr && (clear_data != wwt_pkg::CLEAR_KEY);
  endsequence

  sequence s_closed_clear;
    enable && window_mode && clear_wr && (count_q < win_cyc);
  endsequence

  sequence s_good_clear;
    enable && clear_wr && (clear_data == wwt_pkg::CLEAR_KEY) && !(window_mode && count_q < win_cyc) && !expire;
  endsequence

  bad_key_reset_a: assert property (s_bad_key ##1 !clear_wr |-> sys_reset_req ##1 !sys_reset_req)
    else $error("Wrong clear key did not give a one-cycle reset request.");

  closed_clear_reset_a: assert property (s_closed_clear |=> sys_reset_req && count_q == 0)
    else $error("Clear in closed window did not request reset.");

  good_clear_restart_a: assert property (s_good_clear |=> count_q == 0 && !sys_reset_req)
    else $error("Accepted clear did not restart the counter.");

  timeout_reset_a: assert property (enable && tick && !clear_wr && !window_mode && count_inc == to_cyc
      |=> sys_reset_req && count_q == 0)
    else $error("Normal time-out did not request reset.");

  window_total_a: assert property (enable && tick && !clear_wr && window_mode && count_inc == win_cyc + to_cyc
      |=> sys_reset_req)
    else $error("Window total period did not end in reset.");

  no_early_reset_a: assert property (sys_reset_req |-> $past(clr_bad) || $past(count_inc) >= $past(limit))
    else $error("Reset requested before the period ended.");

  warn_point_a: assert property (enable && tick && !window_mode && to_cyc > ew_cyc && count_inc == ew_cyc
      |=> early_warn_flag)
    else $error("Normal early warning missed its offset.");

  window_warn_a: assert property (enable && tick && window_mode && count_inc == win_cyc
      |=> early_warn_flag)
    else $error("Window early warning missed the open edge.");

  late_warn_none_a: assert property ($rose(early_warn_flag) |-> $past(window_mode) || $past(ew_cyc < to_cyc))
    else $error("Early warning rose although its point lies past time-out.");

  int_enable_a: assert property (int_en_set_wr |=> early_warn_int_en ##0 (early_warn_int == early_warn_flag))
    else $error("Interrupt enable set strobe not honoured.");

  int_disable_a: assert property (int_en_clr_wr && !int_en_set_wr |=> !early_warn_int_en && !early_warn_int)
    else $error("Interrupt enable clear strobe not honoured.");

  flag_clear_a: assert property (flag_wr && flag_wr_data && !ew_hit |=> !early_warn_flag)
    else $error("Writing one did not clear the warning flag.");

  flag_hold_a: assert property (early_warn_flag && !(flag_wr && flag_wr_data) |=> early_warn_flag)
    else $error("Warning flag dropped without a clear.");

  // Ticks with no clear pending, so that a service write cannot mask the counting checks.
  sequence s_normal_tick;
    enable && tick && !window_mode && !clear_wr;
  endsequence

  sequence s_window_tick;
    enable && tick && window_mode && !clear_wr;
  endsequence

  sequence s_example_tick;
    enable && tick && !window_mode && !clear_wr && (timeout_period_sel == 4'h2);
  endsequence

  idle_count_zero_a: assert property (!enable |=> count_q == '0)
    else $error("Counter not held at zero while disabled.");

  idle_no_reset_a: assert property (!enable |=> !sys_reset_req)
    else $error("Reset requested while disabled.");

  enable_start_a: assert property ($rose(enable) |-> count_q == '0)
    else $error("Counting did not start from zero.");

  tick_advance_a: assert property (enable && tick && !clear_wr && (count_inc < limit)
      |=> count_q == $past(count_inc))
    else $error("Tick did not advance the counter.");

  count_hold_a: assert property (enable && !tick && !clear_wr |=> $stable(count_q))
    else $error("Counter moved without a tick.");

  reset_clears_count_a: assert property (sys_reset_req |-> count_q == '0)
    else $error("Reset request left the counter running.");

  shortest_period_a: assert property (timeout_period_sel == 4'h0 |-> to_cyc == CW'(wwt_pkg::SHORTEST_CYC))
    else $error("Shortest period has the wrong length.");

  longest_period_a: assert property (timeout_period_sel >= wwt_pkg::SEL_MAX
      |-> to_cyc == CW'(wwt_pkg::LONGEST_CYC))
    else $error("Longest period has the wrong length.");

  window_shortest_a: assert property (window_period_sel == 4'h0 |-> win_cyc == CW'(wwt_pkg::SHORTEST_CYC))
    else $error("Shortest closed window has the wrong length.");

  window_longest_a: assert property (window_period_sel >= wwt_pkg::SEL_MAX
      |-> win_cyc == CW'(wwt_pkg::LONGEST_CYC))
    else $error("Longest closed window has the wrong length.");

  closed_end_quiet_a: assert property (s_window_tick ##0 (count_inc == win_cyc) |=> !sys_reset_req)
    else $error("Closed window end alone requested reset.");

  example_warn_a: assert property (s_example_tick ##0 (early_warn_offset == 4'h1 && count_inc == 17'h00010)
      |=> early_warn_flag)
    else $error("Early warning missed tick sixteen of the example setting.");

  example_reset_a: assert property (s_example_tick ##0 (count_inc == 17'h00020) |=> sys_reset_req)
    else $error("Reset missed tick thirty-two of the example setting.");

  late_point_quiet_a: assert property (s_normal_tick ##0 (ew_cyc >= to_cyc) |=> !$rose(early_warn_flag))
    else $error("Early warning rose with its point past time-out.");

  normal_warn_exact_a: assert property ($rose(early_warn_flag) && !$past(window_mode)
      |-> $past(count_inc == ew_cyc))
    else $error("Normal early warning rose away from its offset.");

  window_warn_exact_a: assert property ($rose(early_warn_flag) && $past(window_mode)
      |-> $past(count_inc == win_cyc))
    else $error("Window early warning rose away from the open edge.");

  normal_clear_any_a: assert property (enable && !window_mode && clear_wr && !expire
      && (clear_data == wwt_pkg::CLEAR_KEY) |=> !sys_reset_req && count_q == '0)
    else $error("Normal mode refused a key write.");

  open_clear_ok_a: assert property (enable && window_mode && clear_wr && !expire && (count_q >= win_cyc)
      && (clear_data == wwt_pkg::CLEAR_KEY) |=> !sys_reset_req && count_q == '0)
    else $error("Open window refused a key write.");

  normal_not_closed_a: assert property (!window_mode |-> phase != wwt_pkg::WWT_CLOSED)
    else $error("Closed window shown in Normal mode.");

  idle_phase_a: assert property (!enable |-> phase == wwt_pkg::WWT_IDLE)
    else $error("Phase not idle while disabled.");

  int_gated_a: assert property (!early_warn_int_en |-> !early_warn_int)
    else $error("Interrupt raised while disabled.");

  int_en_stable_a: assert property (!int_en_set_wr && !int_en_clr_wr |=> $stable(early_warn_int_en))
    else $error("Interrupt enable changed without a strobe.");

  int_flag_pass_a: assert property (early_warn_int_en && early_warn_flag |-> early_warn_int)
    else $error("Enabled warning flag did not raise the interrupt.");

  zero_write_keeps_a: assert property (early_warn_flag && flag_wr && !flag_wr_data |=> early_warn_flag)
    else $error("Writing zero cleared the warning flag.");

  set_beats_clear_a: assert property (ew_hit && flag_wr && flag_wr_data |=> early_warn_flag)
    else $error("Clear write beat a warning in the same cycle.");

endmodule

// ### hdl/wwt_pkg.sv
package wwt_pkg;

  localparam int unsigned      OSC_HZ         = 1024;
  localparam int unsigned      SHORTEST_MS    = 8;
  localparam int unsigned      LONGEST_MS     = 16000;
  localparam int unsigned      SHORTEST_CYC   = (SHORTEST_MS * OSC_HZ) / 1000;
  localparam int unsigned      LONGEST_CYC    = 16384;
  localparam int unsigned      SEL_COUNT      = 12;
  localparam logic [3:0]       SEL_MAX        = 4'hB;
  localparam int unsigned      CNT_W          = 17;
  localparam logic [7:0]       CLEAR_KEY      = 8'hA5;
  localparam logic [16:0]      CNT_RESET      = 17'h00000;
  localparam logic             INT_EN_RESET   = 1'b0;
  localparam logic             FLAG_RESET     = 1'b0;

  typedef enum logic [1:0] {
    WWT_IDLE   = 2'b00,
    WWT_CLOSED = 2'b01,
    WWT_OPEN   = 2'b10
  } wwt_phase_t;

endpackage

// ### hdl/wwt_period_dec.sv
`timescale 1ns/1ps
module wwt_period_dec #(
  parameter int unsigned CW = 17
) (
  input  wire logic [3:0]    sel,
  output logic      [CW-1:0] cycles
);

  logic [3:0] sel_c;

  // Codes above the last selectable period saturate rather than wrap.
  always_comb begin
    sel_c = (sel > wwt_pkg::SEL_MAX) ? wwt_pkg::SEL_MAX : sel;
    cycles = CW'(wwt_pkg::SHORTEST_CYC) << sel_c;
  end

endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic                core_clk;
  logic                rst;
  logic                osc_clk_in;
  logic                enable;
  logic                window_mode;
  logic [3:0]          timeout_period_sel;
  logic [3:0]          window_period_sel;
  logic [3:0]          early_warn_offset;
  logic                clear_wr;
  logic [7:0]          clear_data;
  logic                int_en_set_wr;
  logic                int_en_clr_wr;
  logic                flag_wr;
  logic                flag_wr_data;
  logic                sys_reset_req;
  logic                early_warn_int;
  logic                early_warn_flag;
  logic                early_warn_int_en;
  logic [16:0]         count;
  wwt_pkg::wwt_phase_t phase;
  logic                osc_q;
  int                  tk;
  int                  w_tk;
  int                  r_tk;
  int                  num_errors;
  int                  compares;

  wwt_core u_wwt_core (.core_clk(core_clk), .rst(rst), .osc_clk_in(osc_clk_in), .enable(enable),
    .window_mode(window_mode), .timeout_period_sel(timeout_period_sel), .window_period_sel(window_period_sel),
    .early_warn_offset(early_warn_offset), .clear_wr(clear_wr), .clear_data(clear_data),
    .int_en_set_wr(int_en_set_wr), .int_en_clr_wr(int_en_clr_wr), .flag_wr(flag_wr),
    .flag_wr_data(flag_wr_data), .sys_reset_req(sys_reset_req), .early_warn_int(early_warn_int),
    .early_warn_flag(early_warn_flag), .early_warn_int_en(early_warn_int_en), .count(count), .phase(phase));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // The oscillator toggles every core cycle, the fastest rate the tick detector accepts.
  always @(posedge core_clk) osc_clk_in <= #1 ~osc_clk_in;

  // Own tick count since period start; any clear write restarts it, so an immediate reset reads 0.
  always @(posedge core_clk) begin
    osc_q <= osc_clk_in;
    if (rst || !enable || clear_wr) tk <= 0;
    else if (osc_clk_in && !osc_q) tk <= tk + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge core_clk);
    #1 s = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic measure(input logic m, input logic [3:0] p, input logic [3:0] w, input logic [3:0] o,
                         input int ca, input logic [7:0] cv);
    window_mode = m;
    timeout_period_sel = p;
    window_period_sel = w;
    early_warn_offset = o;
    clear_data = cv;
    flag_wr_data = 1'b1;
    pulse(flag_wr);
    enable = 1'b1;
    w_tk = -1;
    r_tk = -1;
    for (int n = 0; n < 40000 && r_tk < 0; n++) begin
      @(posedge core_clk);
      #1;
      if (early_warn_flag === 1'b1 && w_tk < 0) w_tk = tk;
      if (sys_reset_req === 1'b1) r_tk = tk;
      clear_wr = (r_tk < 0) && (tk == ca);
      if (clear_wr) ca = -1;
    end
    enable = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_reset_vals;
    chk(early_warn_int_en, 1'b0);
    chk({early_warn_flag, early_warn_int, sys_reset_req}, 3'h0);
  endtask

  task automatic t_phase;
    window_mode = 1'b1;
    {timeout_period_sel, window_period_sel} = 8'h00;
    enable = 1'b1;
    while (tk < 4) begin
      @(posedge core_clk);
      #1;
    end
    chk(count, 17'h00004);
    chk(phase, wwt_pkg::WWT_CLOSED);
    while (tk < 8) begin
      @(posedge core_clk);
      #1;
    end
    chk(phase, wwt_pkg::WWT_OPEN);
    enable = 1'b0;
    @(posedge core_clk);
    #1;
    chk({count, phase}, {17'h00000, wwt_pkg::WWT_IDLE});
  endtask

  task automatic t_ew_normal;
    pulse(int_en_set_wr);
    measure(1'b0, 4'h2, 4'h0, 4'h1, -1, 8'h00);
    chk(w_tk, 16);
    chk(r_tk, 32);
    chk(early_warn_int, 1'b1);
  endtask

  task automatic t_int_ctrl;
    flag_wr_data = 1'b0;
    pulse(flag_wr);
    chk(early_warn_flag, 1'b1);
    pulse(int_en_clr_wr);
    chk({early_warn_int_en, early_warn_int}, 2'h0);
    pulse(int_en_set_wr);
    chk(early_warn_int, 1'b1);
    flag_wr_data = 1'b1;
    pulse(flag_wr);
    chk({early_warn_flag, early_warn_int}, 2'h0);
  endtask

  task automatic t_sweep;
    for (int p = 0; p < 12; p++) begin
      measure(1'b0, p[3:0], 4'h0, 4'hF, -1, 8'h00);
      chk(r_tk, 8 << p);
      chk(w_tk, -1);
    end
  endtask

  task automatic t_clear;
    measure(1'b0, 4'h2, 4'h0, 4'hF, 20, 8'hA5);
    chk(r_tk, 32);
    measure(1'b0, 4'h2, 4'h0, 4'hF, 5, 8'h5A);
    chk(r_tk, 0);
  endtask

  task automatic t_window;
    measure(1'b1, 4'h0, 4'h1, 4'hF, -1, 8'h00);
    chk(w_tk, 16);
    chk(r_tk, 24);
    measure(1'b1, 4'h0, 4'h1, 4'hF, 10, 8'hA5);
    chk(r_tk, 0);
    measure(1'b1, 4'h0, 4'h1, 4'hF, 20, 8'hA5);
    chk(r_tk, 24);
    measure(1'b0, 4'h0, 4'h1, 4'hF, 5, 8'hA5);
    chk(r_tk, 8);
  endtask

  task automatic close_out;
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    close_out();
  end

  initial begin
    {osc_clk_in, enable, window_mode, clear_wr, int_en_set_wr, int_en_clr_wr, flag_wr, flag_wr_data} = 8'h00;
    {timeout_period_sel, window_period_sel, early_warn_offset, clear_data} = 20'h00000;
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    t_reset_vals();
    t_phase();
    t_ew_normal();
    t_int_ctrl();
    t_sweep();
    t_clear();
    t_window();
    close_out();
  end
endmodule
